// ==== hw/fpsf_defs.vh ====
/*
 fpsf_defs.vh: constants for the floating-point status field control block:
 field layout, status register layout, register offsets, encodings.
 assumes: included by hw/fpsf_ctrl.v only; definitions only.
*/
`ifndef FPSF_DEFS_VH
`define FPSF_DEFS_VH

// status field layout
`define FPSF_FTZ 0
`define FPSF_WRE 1
`define FPSF_PC_LO 2
`define FPSF_RC_LO 4
`define FPSF_TD 6
`define FPSF_FLAG_LO 7
// flag order inside the six flag bits
`define FPSF_V 0
`define FPSF_D 1
`define FPSF_Z 2
`define FPSF_O 3
`define FPSF_U 4
`define FPSF_I 5

// 64-bit status register layout
`define FPSF_TRAPS_LO 0
`define FPSF_SF0_LO 6
`define FPSF_SF1_LO 19
`define FPSF_SF2_LO 32
`define FPSF_SF3_LO 45

// axi register byte offsets
`define FPSF_REG_STAT_LO 8'h00
`define FPSF_REG_STAT_HI 8'h04
`define FPSF_REG_MODEL 8'h08
`define FPSF_REG_IRQ_STAT 8'h0C
`define FPSF_REG_IRQ_MASK 8'h10

// reset values
`define FPSF_STAT_RST 64'h0000_0000_0000_003F
`define FPSF_MASK_RST 4'h0

// rounding encodings
`define FPSF_RND_NEAR 2'h0
`define FPSF_RND_DOWN 2'h1
`define FPSF_RND_UP 2'h2
`define FPSF_RND_ZERO 2'h3

// instruction precision completer
`define FPSF_PCC_SINGLE 3'h0
`define FPSF_PCC_DOUBLE 3'h1
`define FPSF_PCC_NONE 3'h2
`define FPSF_PCC_PAR 3'h3
`define FPSF_PCC_NPAR 3'h4

// axi responses
`define FPSF_RESP_OKAY 2'h0
`define FPSF_RESP_SLVERR 2'h2

`endif

// ==== hw/fpsf_ctrl.v ====
/*
 fpsf_ctrl.v: control and status logic for the floating-point status
 register: model and rounding decode, flush-to-zero, trap resolve, flags.
 assumes: single core clock; execution units present one result per cycle
 on the res* ports; software reaches the register over AXI4-Lite.
*/
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "fpsf_defs.vh"
module fpsf_ctrl (
	input wire mclk,
	input wire nrst,
	// axi4-lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire irq,
	// instruction side
	input wire [1:0] statusSelect,
	input wire [2:0] precisionCompleter,
	output wire [1:0] roundingDirection,
	output wire [6:0] precisionBits,
	output wire [4:0] exponentBits,
	output wire modelReserved,
	output wire [5:0] trapDisableEff,
	// result from execution
	input wire resValid,
	input wire [1:0] resField,
	input wire [79:0] resValue,
	input wire resTiny,
	input wire [5:0] resExc,
	output reg outValid,
	output reg [79:0] outValue,
	output reg outFault,
	output reg [5:0] outFaultCause
);
	localparam WR_IDLE = 1'b0;
	localparam WR_RESP = 1'b1;

	reg [63:0] stat_q;
	reg [63:0] stat_d;
	reg [3:0] irqStat_q;
	reg [3:0] irqStat_d;
	reg [3:0] irqMask_q;
	reg [3:0] irqMask_d;
	reg [1:0] lastRound_q;
	reg [2:0] lastModel_q;
	reg wrState_q;
	reg [7:0] awAddr_q;
	reg awHeld_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	reg wHeld_q;

	// extract one 13-bit field (0 main, 1..3 alternates)
	function [12:0] fieldOf;
		input [63:0] s;
		input [1:0] idx;
		begin
			case (idx)
			2'd0: fieldOf = s[`FPSF_SF0_LO +: 13];
			2'd1: fieldOf = s[`FPSF_SF1_LO +: 13];
			2'd2: fieldOf = s[`FPSF_SF2_LO +: 13];
			default: fieldOf = s[`FPSF_SF3_LO +: 13];
			endcase
		end
	endfunction

	// effective trap disables for a field
	function [5:0] trapsOf;
		input [63:0] s;
		input [1:0] idx;
		reg [12:0] f;
		begin
			f = fieldOf(s, idx);
			if (idx != 2'd0 && f[`FPSF_TD])
				trapsOf = 6'h3F;
			else
				trapsOf = s[`FPSF_TRAPS_LO +: 6];
		end
	endfunction

	// computation model decode
	wire [12:0] selField = fieldOf(stat_q, statusSelect);
	wire selWre = selField[`FPSF_WRE];
	wire [1:0] selPc = selField[`FPSF_PC_LO +: 2];
	reg [6:0] precD;
	reg [4:0] expD;
	reg rsvD;
	always @* begin
		precD = 7'd64;
		expD = 5'd17;
		rsvD = 1'b0;
		case (precisionCompleter)
		`FPSF_PCC_SINGLE: begin
			precD = 7'd24;
			expD = selWre ? 5'd17 : 5'd8;
		end
		`FPSF_PCC_DOUBLE: begin
			precD = 7'd53;
			expD = selWre ? 5'd17 : 5'd11;
		end
		`FPSF_PCC_NONE: begin
			expD = selWre ? 5'd17 : 5'd15;
			case (selPc)
			2'b00: precD = 7'd24;
			2'b10: precD = 7'd53;
			2'b11: precD = 7'd64;
			default: begin
				precD = 7'd0;
				expD = 5'd0;
				rsvD = 1'b1;
			end
			endcase
		end
		`FPSF_PCC_PAR: begin
			precD = 7'd24;
			expD = 5'd8;
		end
		default: begin
			precD = 7'd64;
			expD = 5'd17;
		end
		endcase
	end
	assign precisionBits = precD;
	assign exponentBits = expD;
	assign modelReserved = rsvD;
	// rc code passes straight through: 00 near, 01 down, 10 up, 11 zero
	assign roundingDirection = selField[`FPSF_RC_LO +: 2];
	assign trapDisableEff = trapsOf(stat_q, statusSelect);

	// result path: flush-to-zero and exception resolve
	wire [12:0] resF = fieldOf(stat_q, resField);
	wire [5:0] resTd = trapsOf(stat_q, resField);
	wire uflowOn = ~resTd[`FPSF_U];
	wire doFlush = resTiny & resF[`FPSF_FTZ] & ~uflowOn;
	reg [5:0] excEff;
	always @* begin
		excEff = resExc;
		if (doFlush)
			excEff = resExc | (6'h01 << `FPSF_U) | (6'h01 << `FPSF_I);
	end
	wire [5:0] faultCause = excEff & ~resTd;

	// axi write channel
	wire wrFire = awHeld_q & wHeld_q & (wrState_q == WR_IDLE);
	assign s_axi_awready = ~awHeld_q & (wrState_q == WR_IDLE);
	assign s_axi_wready = ~wHeld_q & (wrState_q == WR_IDLE);
	assign s_axi_arready = ~s_axi_rvalid;

	function [31:0] mergeW;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1)
				mergeW[8*k +: 8] = strb[k] ? nw[8*k +: 8] : old[8*k +: 8];
		end
	endfunction

	reg [3:0] evt;
	integer n;
	always @* begin
		stat_d = stat_q;
		irqMask_d = irqMask_q;
		evt = 4'h0;
		// software write replaces the bytes selected by wStrb_q; a write to the irq mask can raise irq for a pending status bit
		if (wrFire) begin
			case (awAddr_q)
			`FPSF_REG_STAT_LO:
				stat_d[31:0] = mergeW(stat_q[31:0], wData_q, wStrb_q);
			`FPSF_REG_STAT_HI:
				stat_d[63:32] = mergeW(stat_q[63:32], wData_q, wStrb_q);
			`FPSF_REG_IRQ_MASK:
				if (wStrb_q[0])
					irqMask_d = wData_q[3:0];
			default: ;
			endcase
		end
		// hardware flag set after write, so set wins
		if (resValid) begin
			for (n = 0; n < 4; n = n + 1)
				if (resField == n)
					evt[n] = 1'b1;
			case (resField)
			2'd0: stat_d[`FPSF_SF0_LO + `FPSF_FLAG_LO +: 6] =
				stat_d[`FPSF_SF0_LO + `FPSF_FLAG_LO +: 6] | excEff;
			2'd1: stat_d[`FPSF_SF1_LO + `FPSF_FLAG_LO +: 6] =
				stat_d[`FPSF_SF1_LO + `FPSF_FLAG_LO +: 6] | excEff;
			2'd2: stat_d[`FPSF_SF2_LO + `FPSF_FLAG_LO +: 6] =
				stat_d[`FPSF_SF2_LO + `FPSF_FLAG_LO +: 6] | excEff;
			default: stat_d[`FPSF_SF3_LO + `FPSF_FLAG_LO +: 6] =
				stat_d[`FPSF_SF3_LO + `FPSF_FLAG_LO +: 6] | excEff;
			endcase
			if (|faultCause == 1'b0)
				evt = 4'h0;
		end
		stat_d[`FPSF_SF0_LO + `FPSF_TD] = 1'b0;
		stat_d[63:58] = 6'h00;
		// irq status: bit n = enabled fault raised by field n, w1c, set wins
		irqStat_d = irqStat_q;
		if (wrFire && awAddr_q == `FPSF_REG_IRQ_STAT && wStrb_q[0])
			irqStat_d = irqStat_q & ~wData_q[3:0];
		irqStat_d = irqStat_d | evt;
	end
	assign irq = |(irqStat_q & irqMask_q);

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stat_q <= `FPSF_STAT_RST;
			irqStat_q <= 4'h0;
			irqMask_q <= `FPSF_MASK_RST;
			wrState_q <= WR_IDLE;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FPSF_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `FPSF_RESP_OKAY;
			outValid <= 1'b0;
			outValue <= 80'h0;
			outFault <= 1'b0;
			outFaultCause <= 6'h00;
			lastRound_q <= 2'h0;
			lastModel_q <= 3'h0;
		end else begin
			stat_q <= stat_d;
			irqStat_q <= irqStat_d;
			irqMask_q <= irqMask_d;
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_q <= s_axi_awaddr;
				awHeld_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				wHeld_q <= 1'b1;
			end
			case (wrState_q)
			WR_IDLE: begin
				if (wrFire) begin
					awHeld_q <= 1'b0;
					wHeld_q <= 1'b0;
					s_axi_bvalid <= 1'b1;
					s_axi_bresp <= (awAddr_q == `FPSF_REG_STAT_LO ||
						awAddr_q == `FPSF_REG_STAT_HI ||
						awAddr_q == `FPSF_REG_IRQ_STAT ||
						awAddr_q == `FPSF_REG_IRQ_MASK) ?
						`FPSF_RESP_OKAY : `FPSF_RESP_SLVERR;
					wrState_q <= WR_RESP;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
					wrState_q <= WR_IDLE;
				end
			end
			default: wrState_q <= WR_IDLE;
			endcase
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `FPSF_RESP_OKAY;
				case (s_axi_araddr)
				`FPSF_REG_STAT_LO: s_axi_rdata <= stat_q[31:0];
				`FPSF_REG_STAT_HI: s_axi_rdata <= stat_q[63:32];
				`FPSF_REG_MODEL: s_axi_rdata <= {14'h0, lastModel_q,
					lastRound_q, modelReserved, exponentBits, precisionBits};
				`FPSF_REG_IRQ_STAT: s_axi_rdata <= {28'h0, irqStat_q};
				`FPSF_REG_IRQ_MASK: s_axi_rdata <= {28'h0, irqMask_q};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `FPSF_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			lastRound_q <= roundingDirection;
			lastModel_q <= precisionCompleter;
			outValid <= resValid;
			outFault <= resValid & (|faultCause);
			outFaultCause <= resValid ? faultCause : 6'h00;
			if (doFlush)
				outValue <= {resValue[79], 79'h0};
			else
				outValue <= resValue;
		end
	end
endmodule

// ==== tb/fpsf_ctrl_sva.sv ====
/*
 fpsf_ctrl_sva.sv: port checker for fpsf_ctrl.
 assumes: bound to every fpsf_ctrl instance.
*/
`timescale 1ns/1ns
module fpsf_ctrl_sva (
	input wire mclk,
	input wire nrst,
	input wire [1:0] statusSelect,
	input wire [2:0] precisionCompleter,
	input wire [6:0] precisionBits,
	input wire [4:0] exponentBits,
	input wire modelReserved,
	input wire [5:0] trapDisableEff,
	input wire resValid,
	input wire [1:0] resField,
	input wire [79:0] resValue,
	input wire outValid,
	input wire [79:0] outValue,
	input wire outFault,
	input wire [5:0] outFaultCause,
	input wire irq,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	chk_result_lat: assert property (resValid |=> outValid)
		else $error("result not answered");
	chk_model_sd: assert property (
		precisionCompleter < 3'h2 |-> precisionBits ==
		(precisionCompleter[0] ? 7'h35 : 7'h18) &&
		(exponentBits == 5'h11 ||
		exponentBits == (precisionCompleter[0] ? 5'h0B : 5'h08)))
		else $error("single or double model wrong");
	chk_model_par: assert property (
		precisionCompleter == 3'h3 |->
		precisionBits == 7'h18 && exponentBits == 5'h08)
		else $error("parallel model wrong");
	chk_model_npar: assert property (
		precisionCompleter > 3'h3 |->
		precisionBits == 7'h40 && exponentBits == 5'h11)
		else $error("non-parallel model wrong");
	chk_model_rsvd: assert property (
		modelReserved |-> precisionCompleter == 3'h2 &&
		precisionBits == 7'h00)
		else $error("reserved model flagged wrongly");
	chk_flush_shape: assert property (
		resValid |=> outValue == $past(resValue) ||
		outValue == {$past(resValue[79]), 79'h0})
		else $error("result neither passed nor signed zero");
	chk_fault_mask: assert property (
		resValid && resField == statusSelect |=>
		(outFaultCause & $past(trapDisableEff)) == 6'h00 &&
		outFault == |outFaultCause)
		else $error("fault cause not masked");
	chk_irq_source: assert property (
		$rose(irq) |-> outFault || $past(outFault) ||
		$past(s_axi_awvalid && s_axi_awready, 2) ||
		$past(s_axi_wvalid && s_axi_wready, 2))
		else $error("interrupt without a fault");
endmodule
bind fpsf_ctrl fpsf_ctrl_sva i_sva (
	.mclk(mclk), .nrst(nrst), .statusSelect(statusSelect),
	.precisionCompleter(precisionCompleter),
	.precisionBits(precisionBits), .exponentBits(exponentBits),
	.modelReserved(modelReserved), .trapDisableEff(trapDisableEff),
	.resValid(resValid), .resField(resField), .resValue(resValue),
	.outValid(outValid), .outValue(outValue), .outFault(outFault),
	.outFaultCause(outFaultCause), .irq(irq),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready)
);

// ==== tb/tb.sv ====
/*
 tb.sv: self-checking bench for fpsf_ctrl.
 assumes: design and checker compiled first.
*/
`timescale 1ns/1ns
module tb;
	logic mclk = 0, nrst = 0, resValid = 0, resTiny = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] statusSelect = 0, resField = 0;
	logic [2:0] precisionCompleter = 0;
	logic [79:0] resValue = 0;
	logic [5:0] resExc = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, irq, modelReserved, outValid, outFault;
	wire [1:0] s_axi_bresp, s_axi_rresp, roundingDirection;
	wire [31:0] s_axi_rdata;
	wire [6:0] precisionBits;
	wire [4:0] exponentBits;
	wire [5:0] trapDisableEff, outFaultCause;
	wire [79:0] outValue;
	int failures = 0, comparisons = 0;
	logic [86:0] bq[$], rq[$], oq[$];
	fpsf_ctrl i_dut (
		.mclk(mclk), .nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .irq(irq),
		.statusSelect(statusSelect),
		.precisionCompleter(precisionCompleter),
		.roundingDirection(roundingDirection),
		.precisionBits(precisionBits), .exponentBits(exponentBits),
		.modelReserved(modelReserved), .trapDisableEff(trapDisableEff),
		.resValid(resValid), .resField(resField), .resValue(resValue),
		.resTiny(resTiny), .resExc(resExc), .outValid(outValid),
		.outValue(outValue), .outFault(outFault),
		.outFaultCause(outFaultCause)
	);
	initial forever #4 mclk = ~mclk;
	task cmp(input [86:0] g, e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task conclude;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk) begin
		if (s_axi_bvalid && s_axi_bready) cmp(s_axi_bresp, bq.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (outValid) cmp({outFault, outFaultCause, outValue}, oq.pop_front());
	end
	task wr(input [7:0] a, input [31:0] d, input [1:0] r);
		logic ta, tw;
		ta = 0;
		tw = 0;
		bq.push_back(r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ta && tw)) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) ta = 1;
			if (s_axi_wvalid && s_axi_wready) tw = 1;
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end
		do @(posedge mclk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
	endtask
	task rd(input [7:0] a, input [33:0] e);
		rq.push_back(e);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge mclk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
	endtask
	task rs(input [1:0] f, input [79:0] v, input t, input [5:0] x,
		input [86:0] e);
		@(posedge mclk);
		resValid <= 1;
		resField <= f;
		resValue <= v;
		resTiny <= t;
		resExc <= x;
		oq.push_back(e);
	endtask
	task idle;
		@(posedge mclk);
		resValid <= 0;
	endtask
	function [12:0] mdl(input [2:0] c, input [2:0] m);
		case (c)
		0: mdl = {1'b0, 7'h18, m[0] ? 5'h11 : 5'h08};
		1: mdl = {1'b0, 7'h35, m[0] ? 5'h11 : 5'h0B};
		2: mdl = m[2:1] == 1 ? 13'h1000 : {1'b0, m[2:1] == 0 ? 7'h18 :
			m[2:1] == 2 ? 7'h35 : 7'h40, m[0] ? 5'h11 : 5'h0F};
		3: mdl = {1'b0, 7'h18, 5'h08};
		default: mdl = {1'b0, 7'h40, 5'h11};
		endcase
	endfunction
	initial begin
		#100000;
		failures++;
		conclude;
	end
	initial begin
		logic [5:0] t, x, a, f;
		logic [79:0] v;
		void'($urandom(32'h2ae5_c04f));
		repeat (6) @(posedge mclk);
		nrst <= 1;
		rd(8'h00, 34'h0_0000_003F);
		rd(8'h10, 34'h0);
		rd(8'h20, 34'h2_0000_0000);
		wr(8'h24, 32'h0, 2'h2);
		wr(8'h00, 32'hFFFF_FFFF, 2'h0);
		rd(8'h00, 34'h0_FFFF_EFFF);
		wr(8'h04, 32'hFFFF_FFFF, 2'h0);
		rd(8'h04, 34'h0_03FF_FFFF);
		statusSelect <= 1;
		for (int r = 0; r < 4; r++) begin
			wr(8'h00, r << 23, 2'h0);
			@(negedge mclk);
			cmp(roundingDirection, r[1:0]);
		end
		@(posedge mclk);
		statusSelect <= 2;
		for (int m = 0; m < 8; m++) begin
			wr(8'h04, m << 1, 2'h0);
			for (int c = 0; c < 6; c++) begin
				@(posedge mclk);
				precisionCompleter <= c[2:0];
				@(negedge mclk);
				cmp({modelReserved, precisionBits, exponentBits},
					mdl(c[2:0], m[2:0]));
			end
		end
		@(posedge mclk);
		statusSelect <= 1;
		wr(8'h10, 32'h0000_0002, 2'h0);
		wr(8'h00, 32'h0008_0010, 2'h0);
		rs(1, {1'b1, 79'h5}, 1, 6'h00, {1'b1, 6'h20, 1'b1, 79'h0});
		idle;
		rd(8'h00, 34'h0_C008_0010);
		@(negedge mclk);
		cmp(irq, 1'b1);
		wr(8'h0C, 32'h0000_0002, 2'h0);
		wr(8'h00, 32'hC000_0000, 2'h0);
		@(negedge mclk);
		cmp(irq, 1'b0);
		wr(8'h00, 32'h0008_0000, 2'h0);
		rs(1, 80'h1234, 1, 6'h10, {1'b1, 6'h10, 80'h1234});
		idle;
		@(negedge mclk);
		cmp(irq, 1'b1);
		wr(8'h0C, 32'h0000_0002, 2'h0);
		wr(8'h00, 32'h0208_0000, 2'h0);
		@(negedge mclk);
		cmp(trapDisableEff, 6'h3F);
		rs(1, {1'b1, 79'h9}, 1, 6'h3F, {7'h00, 1'b1, 79'h0});
		idle;
		t = $urandom;
		a = 6'h00;
		f = 6'h00;
		wr(8'h00, {26'h0, t}, 2'h0);
		statusSelect <= 0;
		@(negedge mclk);
		cmp(trapDisableEff, t);
		repeat (24) begin
			v = {$urandom, $urandom, $urandom};
			x = $urandom;
			a = a | (x & ~t);
			f = f | x;
			rs(0, v, 0, x, {|(x & ~t), x & ~t, v});
		end
		idle;
		@(negedge mclk);
		cmp(irq, 1'b0);
		rd(8'h00, {2'h0, 13'h0000, f, 7'h00, t});
		rd(8'h0C, {2'h0, 31'h0000_0000, |a});
		repeat (3) @(posedge mclk);
		conclude;
	end
endmodule
